// >>> design/cmbi_bus.sv
// Purpose: System-bus unit of an 8-bit processor, multiplexed AD bus
// Assumes: core_clk is the oscillator input; reset is the processor reset
// Notes:   One machine cycle at a time, asked for by the execution core
//
// Summary of operation
// - Keep 16-bit pointer to next fetch
// - Grant acknowledge low only once bus floats
// - Upper address floats during bus grant
// - Reset output high while held in reset
// - IO/memory select high for IO, floats
// - Refresh strobe low in fetch T3, T4
// - Latch strobe in T1, and fetch T3
// - Capture read data at read strobe rise
// - Write data valid while write strobe low
// - System clock is oscillator divided by two
// - Sample irq at last T-state, ack T2
// - Two status bits encode next cycle
// - AD carries address, then data; floats
// - Reset clears pointer, vector base, refresh
// - Reset disables irqs, mask one, mode zero
// - During reset buses float, strobes inactive
// - One T-state per clock; fetch four
// - Memory 16-bit address, IO port doubled
// - Finish cycle, float, acknowledge until released
// - IO cycles get one automatic wait
// - Refresh counter steps after each fetch
`include "cmbi_params.svh"

module cmbi_bus (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 cmdValid,
  input  wire cmbi_pkg::cmbi_kind_e cmdKind,
  input  wire logic [15:0]          cmdAddr,
  input  wire logic [7:0]           cmdData,
  input  wire logic                 cmdLast,
  input  wire logic                 ptrLoad,
  input  wire logic [15:0]          ptrLoadValue,
  input  wire logic                 intEnableSet,
  input  wire logic                 intEnableClr,
  input  wire logic                 maskLoad,
  input  wire logic [3:0]           maskValue,
  input  wire logic                 modeLoad,
  input  wire logic [1:0]           modeValue,
  input  wire logic                 vectorLoad,
  input  wire logic [7:0]           vectorValue,
  input  wire logic                 busHoldRequest_n,
  input  wire logic                 waitRequest_n,
  input  wire logic                 multiModeIrq,
  input  wire logic [7:0]           adIn,
  output logic                      sysClk_q,
  output logic                      resetOut_q,
  output logic                      busAck_n_q,
  output logic [7:0]                addrHigh_q,
  output logic                      addrHighOe_n_q,
  output logic [7:0]                adOut_q,
  output logic                      adOe_n_q,
  output logic                      ale_q,
  output logic                      rd_n_q,
  output logic                      wr_n_q,
  output logic                      ctrlOe_n_q,
  output logic                      ioMem_q,
  output logic                      refreshStrobe_n_q,
  output logic                      interruptAck_n_q,
  output logic                      cycleStatusLow_q,
  output logic                      cycleStatusHigh_q,
  output logic                      cmdDone_q,
  output logic                      intAckDone_q,
  output logic [7:0]                rdData_q,
  output logic [15:0]               nextFetchPointer_q,
  output logic [3:0]                interruptMaskRegister_q,
  output logic                      intEnable_q,
  output logic [1:0]                intMode_q,
  output logic [7:0]                vectorBase_q,
  output logic [7:0]                refreshCount_q
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [2:0] syncLevel;

  cmbi_sync #(.WIDTH(3), .INIT(32'h0000_0003)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    ({multiModeIrq, waitRequest_n, busHoldRequest_n}),
    .level_q  (syncLevel)
  );

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  cmbi_pkg::cmbi_state_e state_q;
  cmbi_pkg::cmbi_state_e stateD;
  cmbi_pkg::cmbi_kind_e  kind_q;
  cmbi_pkg::cmbi_kind_e  kindNow;
  logic [15:0]           addr_q;
  logic [7:0]            data_q;
  logic                  last_q;
  logic                  intPend_q;

  wire tick      = sysClk_q;
  wire holdReq   = ~syncLevel[0];
  wire waitReq   = ~syncLevel[1];
  wire irqSync   = syncLevel[2];
  wire idle      = (state_q == cmbi_pkg::ST_IDLE);
  wire startAny  = idle && !holdReq && (intPend_q || cmdValid);
  wire newKindIa = intPend_q;

  assign kindNow = idle ? (newKindIa ? cmbi_pkg::CK_INTACK : cmdKind)
                        : kind_q;

  wire isIo     = (kindNow == cmbi_pkg::CK_IO_RD) ||
                  (kindNow == cmbi_pkg::CK_IO_WR);
  wire isWr     = (kindNow == cmbi_pkg::CK_MEM_WR) ||
                  (kindNow == cmbi_pkg::CK_IO_WR);
  wire isIa     = (kindNow == cmbi_pkg::CK_INTACK);
  wire isHalt   = (kindNow == cmbi_pkg::CK_HALT);
  wire fetchLk  = (kindNow == cmbi_pkg::CK_FETCH) || isIa;
  wire usesPtr  = (kindNow == cmbi_pkg::CK_FETCH) ||
                  (kindNow == cmbi_pkg::CK_OPERAND);
  wire fetchMachineCycle = fetchLk;

  wire haltTake = startAny && isHalt && tick;
  wire cycleEnd = tick && ((state_q == cmbi_pkg::ST_T3 && !fetchLk) ||
                           state_q == cmbi_pkg::ST_T4);

  // Strobe window of T2 and any wait states
  wire midD  = (stateD == cmbi_pkg::ST_T2) || (stateD == cmbi_pkg::ST_TWA) ||
               (stateD == cmbi_pkg::ST_TW);
  wire t3D   = (stateD == cmbi_pkg::ST_T3);
  wire rfshD = fetchMachineCycle && (t3D || stateD == cmbi_pkg::ST_T4);
  wire holdD = (stateD == cmbi_pkg::ST_HOLD);
  wire busyD = !holdD && (stateD != cmbi_pkg::ST_IDLE);
  wire aleD  = (stateD == cmbi_pkg::ST_T1) || (t3D && fetchLk);
  wire rdOnD = !isWr && !isIa && (midD || (t3D && !fetchLk));
  wire wrOnD = isWr && (midD || t3D);
  wire iaOnD = isIa && midD;
  wire adDrvD = (stateD == cmbi_pkg::ST_T1) || rfshD || wrOnD;

  // IO port number on both bytes; T1 launches before addr_q loads
  wire [15:0] startAddr = usesPtr ? nextFetchPointer_q : cmdAddr;
  wire [15:0] curAddr   = idle ? startAddr : addr_q;
  wire [15:0] cycAddr   = isIo ? {curAddr[7:0], curAddr[7:0]}
                               : curAddr;
  wire [7:0]  adD   = rfshD ? refreshCount_q :
                      (wrOnD ? data_q : cycAddr[7:0]);
  wire [7:0]  highD = rfshD ? vectorBase_q : cycAddr[15:8];

  // Capture at the rising read or acknowledge strobe
  wire rdRise = tick && ((!rd_n_q && !rdOnD) ||
                         (!interruptAck_n_q && !iaOnD));
  wire intTake = cycleEnd && last_q && irqSync && intEnable_q &&
                 interruptMaskRegister_q[`CMBI_MASK_MULTI];

  // --------------------------------------------------------------------
  // T-state sequencer
  // --------------------------------------------------------------------
  always_comb begin
    stateD = state_q;
    unique case (state_q)
      cmbi_pkg::ST_IDLE: begin
        if (holdReq) begin
          stateD = cmbi_pkg::ST_HOLD;
        end else if ((intPend_q || cmdValid) && !isHalt) begin
          stateD = cmbi_pkg::ST_T1;
        end
      end
      cmbi_pkg::ST_T1: stateD = cmbi_pkg::ST_T2;
      cmbi_pkg::ST_T2: begin
        if (isIo) begin
          stateD = cmbi_pkg::ST_TWA;
        end else if (waitReq) begin
          stateD = cmbi_pkg::ST_TW;
        end else begin
          stateD = cmbi_pkg::ST_T3;
        end
      end
      cmbi_pkg::ST_TWA,
      cmbi_pkg::ST_TW: begin
        stateD = waitReq ? cmbi_pkg::ST_TW : cmbi_pkg::ST_T3;
      end
      cmbi_pkg::ST_T3: begin
        stateD = fetchLk ? cmbi_pkg::ST_T4 : cmbi_pkg::ST_IDLE;
      end
      cmbi_pkg::ST_T4: stateD = cmbi_pkg::ST_IDLE;
      cmbi_pkg::ST_HOLD: begin
        stateD = holdReq ? cmbi_pkg::ST_HOLD : cmbi_pkg::ST_IDLE;
      end
    endcase
  end

  // System clock out; its high phase is the T-state enable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sysClk_q   <= 1'b0;
      resetOut_q <= 1'b1;
      state_q    <= cmbi_pkg::ST_IDLE;
    end else begin
      sysClk_q   <= ~sysClk_q;
      resetOut_q <= 1'b0;
      if (tick) begin
        state_q <= stateD;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      kind_q <= cmbi_pkg::CK_HALT;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      last_q <= 1'b0;
    end else if (startAny && tick && !isHalt) begin
      kind_q <= kindNow;
      addr_q <= startAddr;
      data_q <= cmdData;
      last_q <= isIa ? 1'b0 : cmdLast;
    end
  end

  // --------------------------------------------------------------------
  // Bus pins, registered once per T-state
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busAck_n_q        <= 1'b1;
      addrHigh_q        <= 8'h00;
      addrHighOe_n_q    <= 1'b1;
      adOut_q           <= 8'h00;
      adOe_n_q          <= 1'b1;
      ale_q             <= 1'b0;
      rd_n_q            <= 1'b1;
      wr_n_q            <= 1'b1;
      ctrlOe_n_q        <= 1'b0;
      ioMem_q           <= 1'b0;
      refreshStrobe_n_q <= 1'b1;
      interruptAck_n_q  <= 1'b1;
    end else if (tick) begin
      busAck_n_q        <= !holdD;
      addrHigh_q        <= highD;
      addrHighOe_n_q    <= !busyD;
      adOut_q           <= adD;
      adOe_n_q          <= !(busyD && adDrvD);
      ale_q             <= aleD;
      rd_n_q            <= !rdOnD;
      wr_n_q            <= !wrOnD;
      ctrlOe_n_q        <= holdD;
      ioMem_q           <= busyD && isIo;
      refreshStrobe_n_q <= !rfshD;
      interruptAck_n_q  <= !iaOnD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cycleStatusHigh_q <= 1'b0;
      cycleStatusLow_q  <= 1'b0;
    end else if (startAny && tick) begin
      {cycleStatusHigh_q, cycleStatusLow_q} <=
        isHalt  ? `CMBI_ST_HALT :
        fetchLk ? `CMBI_ST_FETCH :
        isWr    ? `CMBI_ST_WRITE : `CMBI_ST_READ;
    end
  end

  // --------------------------------------------------------------------
  // Answers to the core
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdData_q     <= 8'h00;
      cmdDone_q    <= 1'b0;
      intAckDone_q <= 1'b0;
    end else begin
      if (rdRise) begin
        rdData_q <= adIn;
      end
      cmdDone_q    <= (cycleEnd && !isIa) || haltTake;
      intAckDone_q <= cycleEnd && isIa;
    end
  end

  // --------------------------------------------------------------------
  // Dedicated registers and interrupt state
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nextFetchPointer_q <= `CMBI_PTR_RST;
      refreshCount_q     <= `CMBI_REFRESH_STROBE_N_RST;
      vectorBase_q       <= `CMBI_VEC_RST;
    end else begin
      if (ptrLoad) begin
        nextFetchPointer_q <= ptrLoadValue;
      end else if (cycleEnd && usesPtr) begin
        nextFetchPointer_q <= nextFetchPointer_q + 16'h0001;
      end
      if (cycleEnd && fetchLk) begin
        refreshCount_q <= refreshCount_q + 8'h01;
      end
      if (vectorLoad) begin
        vectorBase_q <= vectorValue;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      interruptMaskRegister_q <= `CMBI_MASK_RST;
      intMode_q               <= `CMBI_MODE_RST;
      intEnable_q             <= 1'b0;
      intPend_q               <= 1'b0;
    end else begin
      if (maskLoad) begin
        interruptMaskRegister_q <= maskValue;
      end
      if (modeLoad) begin
        intMode_q <= modeValue;
      end
      if (startAny && tick && isIa) begin
        intEnable_q <= intEnableSet && !intEnableClr;
        intPend_q   <= 1'b0;
      end else begin
        intEnable_q <= (intEnable_q || intEnableSet) && !intEnableClr;
        intPend_q   <= intPend_q || intTake;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_grant_float: assert property (
    !busAck_n_q |-> adOe_n_q && addrHighOe_n_q && ctrlOe_n_q)
    else $error("grant acknowledged while bus driven");
  chk_reset_out: assert property (
    @(posedge core_clk) disable iff (1'b0) reset |=> resetOut_q)
    else $error("reset output low during reset");
  chk_reset_vals: assert property (
    $past(reset) |-> nextFetchPointer_q == `CMBI_PTR_RST &&
      interruptMaskRegister_q == `CMBI_MASK_RST && !intEnable_q)
    else $error("reset values wrong");
  chk_state_tick: assert property (
    state_q != $past(state_q) |-> $past(tick))
    else $error("state moved off a T-state edge");
  chk_ale_place: assert property (
    ale_q |-> state_q == cmbi_pkg::ST_T1 ||
      (state_q == cmbi_pkg::ST_T3 && fetchLk))
    else $error("latch strobe outside T1 or fetch T3");
  chk_refresh_strobe_n_width: assert property (
    $fell(refreshStrobe_n_q) |-> state_q == cmbi_pkg::ST_T3 ##0
      !refreshStrobe_n_q[*4] ##1 refreshStrobe_n_q)
    else $error("refresh strobe not two T-states");
  chk_wr_data: assert property (
    !wr_n_q |-> !adOe_n_q && adOut_q == data_q)
    else $error("write strobe without write data");
  chk_io_wait: assert property (
    state_q == cmbi_pkg::ST_T2 && isIo && tick
      |=> state_q == cmbi_pkg::ST_TWA)
    else $error("IO cycle missed its own wait");
  chk_io_port: assert property (
    state_q == cmbi_pkg::ST_T1 && isIo |-> addrHigh_q == adOut_q)
    else $error("IO port not on both bytes");
  chk_interrupt_ack_n_t2: assert property (
    $fell(interruptAck_n_q) |-> state_q == cmbi_pkg::ST_T2 && isIa)
    else $error("acknowledge outside T2");
  chk_ptr_step: assert property (
    cycleEnd && usesPtr && !ptrLoad
      |=> nextFetchPointer_q == $past(nextFetchPointer_q) + 16'h0001)
    else $error("pointer did not step");

  cov_fetch: cover property (cycleEnd && kind_q == cmbi_pkg::CK_FETCH);
  cov_io_wr: cover property (cycleEnd && kind_q == cmbi_pkg::CK_IO_WR);
  cov_hold:  cover property ($fell(busAck_n_q));
  cov_intack: cover property (intAckDone_q);

endmodule

// >>> design/cmbi_params.svh
// Purpose: Reset values and fixed codes of the multiplexed bus unit
// Assumes: Included by bare name wherever these values are needed
// Notes:   Definitions only
`ifndef CMBI_PARAMS_SVH
`define CMBI_PARAMS_SVH

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CMBI_PTR_RST    16'h0000
`define CMBI_VEC_RST    8'h00
`define CMBI_REFRESH_STROBE_N_RST   8'h00
`define CMBI_MASK_RST   4'h1
`define CMBI_MODE_RST   2'h0

// ----------------------------------------------------------------------
// Status codes, high bit then low bit
// ----------------------------------------------------------------------
`define CMBI_ST_HALT    2'h0
`define CMBI_ST_WRITE   2'h1
`define CMBI_ST_READ    2'h2
`define CMBI_ST_FETCH   2'h3

// ----------------------------------------------------------------------
// Field positions and timing
// ----------------------------------------------------------------------
`define CMBI_MASK_MULTI 0
`define CMBI_SYNC_DEPTH 3

`endif

// >>> design/cmbi_pkg.sv
// Purpose: Types shared by the multiplexed bus unit
// Assumes: Nothing
// Notes:   Values live in cmbi_params.svh
package cmbi_pkg;

  // Kind of machine cycle asked for by the execution core
  typedef enum logic [2:0] {
    CK_FETCH,
    CK_OPERAND,
    CK_MEM_RD,
    CK_MEM_WR,
    CK_IO_RD,
    CK_IO_WR,
    CK_HALT,
    CK_INTACK
  } cmbi_kind_e;

  // T-state sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_TWA,
    ST_TW,
    ST_T3,
    ST_T4,
    ST_HOLD
  } cmbi_state_e;

endpackage

// >>> design/cmbi_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to core_clk
// Notes:   A change counts once stages two and three agree
`include "cmbi_params.svh"

module cmbi_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] agree;

  // Elaboration check on the width
  if (WIDTH < 1 || WIDTH > 32) begin : g_badWidth
    $error("cmbi_sync: WIDTH out of range");
  end

  assign agree = ~(stage2_q ^ stage3_q);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage1_q <= INIT[WIDTH-1:0];
      stage2_q <= INIT[WIDTH-1:0];
      stage3_q <= INIT[WIDTH-1:0];
      level_q  <= INIT[WIDTH-1:0];
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q  <= (agree & stage3_q) | (~agree & level_q);
    end
  end

endmodule

// >>> testbench/cmbi_bus_partner.sv
// Purpose: Memory, I/O port and interrupt responder on the AD bus
// Assumes: Address is latched while the latch strobe is high
// Notes:   Released AD lines show a pattern that changes every cycle
module cmbi_bus_partner (
  input  wire logic        core_clk,
  input  wire logic        ale_q,
  input  wire logic [7:0]  adOut_q,
  input  wire logic        adOe_n_q,
  input  wire logic [7:0]  addrHigh_q,
  input  wire logic        rd_n_q,
  input  wire logic        wr_n_q,
  input  wire logic        ioMem_q,
  input  wire logic        refreshStrobe_n_q,
  input  wire logic        interruptAck_n_q,
  input  wire logic [7:0]  ackByte,
  output logic      [7:0]  adIn,
  output logic      [15:0] cycAddr,
  output logic      [15:0] refAddr,
  output logic             cycIo
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [0:65535];
  logic [7:0] io [0:255];
  logic [7:0] lastAd = 8'h00;
  logic [7:0] rdByte;

  // ------------------------------------------------------------------
  // Wire level: device, else responder, else floating pattern
  // ------------------------------------------------------------------
  assign rdByte = cycIo ? io[cycAddr[7:0]] : mem[cycAddr];
  assign adIn = !adOe_n_q ? adOut_q
              : !interruptAck_n_q ? ackByte
              : !rd_n_q ? rdByte
              : ~lastAd;

  always @(posedge core_clk) begin
    lastAd <= adIn;
    if (ale_q && refreshStrobe_n_q) begin
      cycAddr <= {addrHigh_q, adOut_q};
      cycIo <= ioMem_q;
    end
    if (ale_q && !refreshStrobe_n_q) begin
      refAddr <= {addrHigh_q, adOut_q};
    end
    if (!wr_n_q && !adOe_n_q && ioMem_q) begin
      io[cycAddr[7:0]] <= adOut_q;
    end
    if (!wr_n_q && !adOe_n_q && !ioMem_q) begin
      mem[cycAddr] <= adOut_q;
    end
  end
endmodule

// >>> testbench/cmbi_bus_tb_top.sv
// Purpose: Self-checking bench for the multiplexed system-bus unit
// Assumes: Partner model answers reads, writes and acknowledges
// Notes:   Inputs change 1 ns after the rising edge
`include "cmbi_params.svh"

module cmbi_bus_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk, reset, cmdValid, cmdLast, ptrLoad, intEnableSet;
  logic intEnableClr, maskLoad, modeLoad, vectorLoad, busHoldRequest_n;
  logic waitRequest_n, multiModeIrq, sysClk_q, resetOut_q, busAck_n_q;
  logic addrHighOe_n_q, adOe_n_q, ale_q, rd_n_q, wr_n_q, ctrlOe_n_q;
  logic ioMem_q, refreshStrobe_n_q, interruptAck_n_q, cycleStatusLow_q;
  logic cycleStatusHigh_q, cmdDone_q, intAckDone_q, intEnable_q, cycIo;
  cmbi_pkg::cmbi_kind_e cmdKind;
  logic [15:0] cmdAddr, ptrLoadValue, nextFetchPointer_q, cycAddr, refAddr;
  logic [7:0]  cmdData, vectorValue, adIn, addrHigh_q, adOut_q, rdData_q;
  logic [7:0]  vectorBase_q, refreshCount_q;
  logic [3:0]  maskValue, interruptMaskRegister_q;
  logic [1:0]  modeValue, intMode_q, st;
  int          errors, numChecks, nRd, n;

  cmbi_bus i_cmbi_bus (
    .core_clk, .reset, .cmdValid, .cmdKind, .cmdAddr, .cmdData, .cmdLast,
    .ptrLoad, .ptrLoadValue, .intEnableSet, .intEnableClr, .maskLoad,
    .maskValue, .modeLoad, .modeValue, .vectorLoad, .vectorValue,
    .busHoldRequest_n, .waitRequest_n, .multiModeIrq, .adIn, .sysClk_q,
    .resetOut_q, .busAck_n_q, .addrHigh_q, .addrHighOe_n_q, .adOut_q,
    .adOe_n_q, .ale_q, .rd_n_q, .wr_n_q, .ctrlOe_n_q, .ioMem_q,
    .refreshStrobe_n_q, .interruptAck_n_q, .cycleStatusLow_q,
    .cycleStatusHigh_q, .cmdDone_q, .intAckDone_q, .rdData_q,
    .nextFetchPointer_q, .interruptMaskRegister_q, .intEnable_q,
    .intMode_q, .vectorBase_q, .refreshCount_q
  );

  cmbi_bus_partner i_cmbi_bus_partner (
    .core_clk, .ale_q, .adOut_q, .adOe_n_q, .addrHigh_q, .rd_n_q, .wr_n_q,
    .ioMem_q, .refreshStrobe_n_q, .interruptAck_n_q, .ackByte(8'hCF),
    .adIn, .cycAddr, .refAddr, .cycIo
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  // One machine cycle; leaves edge count in n, first status in st
  task automatic run_cycle(input cmbi_pkg::cmbi_kind_e k,
                           input logic [15:0] a, input logic [7:0] d,
                           input logic last);
    bit got;
    got = 1'b0;
    n = 0;
    if (sysClk_q !== 1'b1) step();
    cmdKind = k;
    cmdAddr = a;
    cmdData = d;
    cmdLast = last;
    cmdValid = 1'b1;
    while (n < 60 && cmdDone_q !== 1'b1) begin
      step();
      n++;
      if (!got && ale_q === 1'b1) begin
        got = 1'b1;
        st = {cycleStatusHigh_q, cycleStatusLow_q};
      end
    end
    cmdValid = 1'b0;
    chk("cmdDone", 16'(n < 60), 16'h1);
    step();
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("resetOut", resetOut_q, 1'b1);
    chk("pointer", nextFetchPointer_q, 16'h0000);
    chk("vector", vectorBase_q, 8'h00);
    chk("refresh", refreshCount_q, 8'h00);
    chk("mask", interruptMaskRegister_q, 4'h1);
    chk("intOn", intEnable_q, 1'b0);
    chk("mode", intMode_q, 2'h0);
    chk("floats", {addrHighOe_n_q, adOe_n_q}, 2'h3);
    chk("strobes", {rd_n_q, wr_n_q, refreshStrobe_n_q,
                    interruptAck_n_q, ale_q, busAck_n_q}, 6'h3D);
  endtask

  task automatic t_clock();
    logic prev;
    repeat (2) step();
    chk("resetOutLow", resetOut_q, 1'b0);
    repeat (6) begin
      prev = sysClk_q;
      step();
      chk("sysClk", sysClk_q, !prev);
    end
  endtask

  task automatic t_memory();
    int nW;
    run_cycle(cmbi_pkg::CK_MEM_WR, 16'hA5C3, 8'h3C, 1'b0);
    nW = n;
    chk("wrSt", st, `CMBI_ST_WRITE);
    chk("wrMem", i_cmbi_bus_partner.mem[16'hA5C3], 8'h3C);
    chk("wrAddr", cycAddr, 16'hA5C3);
    chk("wrIo", cycIo, 1'b0);
    i_cmbi_bus_partner.mem[16'h5A3C] = 8'h96;
    run_cycle(cmbi_pkg::CK_MEM_RD, 16'h5A3C, 8'h00, 1'b0);
    nRd = n;
    chk("rdSt", st, `CMBI_ST_READ);
    chk("rdByte", rdData_q, 8'h96);
    chk("rdAddr", cycAddr, 16'h5A3C);
    chk("rdLen", 16'(nRd), 16'(nW));
    waitRequest_n = 1'b0;
    run_cycle(cmbi_pkg::CK_HALT, 16'h0000, 8'h00, 1'b0);
    chk("haltLen", 16'(n), 16'h1);
    chk("haltSt", {cycleStatusHigh_q, cycleStatusLow_q},
        `CMBI_ST_HALT);
    fork
      run_cycle(cmbi_pkg::CK_MEM_RD, 16'hA5C3, 8'h00, 1'b0);
      begin
        repeat (10) step();
        waitRequest_n = 1'b1;
      end
    join
    chk("waitLen", 16'(n > nRd), 16'h1);
    chk("waitRd", rdData_q, 8'h3C);
  endtask

  task automatic t_fetch();
    logic [7:0] r0;
    ptrLoad = 1'b1;
    ptrLoadValue = 16'hFFFF;
    vectorLoad = 1'b1;
    vectorValue = 8'h7E;
    step();
    ptrLoad = 1'b0;
    vectorLoad = 1'b0;
    step();
    chk("ptrLoad", nextFetchPointer_q, 16'hFFFF);
    i_cmbi_bus_partner.mem[16'hFFFF] = 8'hC3;
    r0 = refreshCount_q;
    run_cycle(cmbi_pkg::CK_FETCH, 16'h1234, 8'h00, 1'b0);
    chk("fetchSt", st, `CMBI_ST_FETCH);
    chk("opcode", rdData_q, 8'hC3);
    chk("fetchAddr", cycAddr, 16'hFFFF);
    chk("ptrWrap", nextFetchPointer_q, 16'h0000);
    chk("refCount", refreshCount_q, r0 + 8'h01);
    chk("refAddr", refAddr, {8'h7E, r0});
    chk("fetchLen", 16'(n - nRd), 16'h2);
    i_cmbi_bus_partner.mem[16'h0000] = 8'h5E;
    run_cycle(cmbi_pkg::CK_OPERAND, 16'h1234, 8'h00, 1'b0);
    chk("operand", rdData_q, 8'h5E);
    chk("ptrStep", nextFetchPointer_q, 16'h0001);
    chk("refKeep", refreshCount_q, r0 + 8'h01);
  endtask

  task automatic t_io();
    run_cycle(cmbi_pkg::CK_IO_WR, 16'h77D2, 8'hE1, 1'b0);
    chk("ioWr", i_cmbi_bus_partner.io[8'hD2], 8'hE1);
    chk("ioAddr", cycAddr, 16'hD2D2);
    chk("ioSel", cycIo, 1'b1);
    chk("ioWrLen", 16'(n - nRd), 16'h2);
    i_cmbi_bus_partner.io[8'h4B] = 8'h69;
    run_cycle(cmbi_pkg::CK_IO_RD, 16'h004B, 8'h00, 1'b0);
    chk("ioRd", rdData_q, 8'h69);
    chk("ioRdSt", st, `CMBI_ST_READ);
    chk("ioRdLen", 16'(n - nRd), 16'h2);
  endtask

  task automatic t_hold();
    int k;
    busHoldRequest_n = 1'b0;
    k = 0;
    while (k < 40 && busAck_n_q !== 1'b0) begin
      step();
      k++;
    end
    chk("grant", 16'(k < 40), 16'h1);
    chk("busFloat", {addrHighOe_n_q, adOe_n_q, ctrlOe_n_q},
        3'h7);
    cmdKind = cmbi_pkg::CK_MEM_RD;
    cmdAddr = 16'h5A3C;
    cmdValid = 1'b1;
    repeat (12) step();
    chk("holdKeep", {busAck_n_q, ctrlOe_n_q, cmdDone_q}, 3'h2);
    busHoldRequest_n = 1'b1;
    run_cycle(cmbi_pkg::CK_MEM_RD, 16'h5A3C, 8'h00, 1'b0);
    chk("afterHold", rdData_q, 8'h96);
    chk("ackOff", busAck_n_q, 1'b1);
  endtask

  task automatic t_irq();
    int k;
    bit ackSeen;
    logic [15:0] p0;
    maskLoad = 1'b1;
    maskValue = 4'h0;
    modeLoad = 1'b1;
    modeValue = 2'h2;
    intEnableSet = 1'b1;
    intEnableClr = 1'b1;
    step();
    chk("clrWins", intEnable_q, 1'b0);
    chk("maskLd", interruptMaskRegister_q, 4'h0);
    chk("modeLd", intMode_q, 2'h2);
    maskLoad = 1'b0;
    modeLoad = 1'b0;
    intEnableClr = 1'b0;
    step();
    intEnableSet = 1'b0;
    multiModeIrq = 1'b1;
    repeat (6) step();
    run_cycle(cmbi_pkg::CK_FETCH, 16'h0000, 8'h00, 1'b1);
    ackSeen = 1'b0;
    repeat (20) begin
      step();
      if (interruptAck_n_q === 1'b0) ackSeen = 1'b1;
    end
    chk("masked", ackSeen, 1'b0);
    maskLoad = 1'b1;
    maskValue = 4'h1;
    step();
    maskLoad = 1'b0;
    run_cycle(cmbi_pkg::CK_FETCH, 16'h0000, 8'h00, 1'b1);
    p0 = nextFetchPointer_q;
    k = 0;
    while (k < 40 && intAckDone_q !== 1'b1) begin
      step();
      k++;
      if (interruptAck_n_q === 1'b0) ackSeen = 1'b1;
    end
    chk("ackDone", 16'(k < 40), 16'h1);
    chk("ackStrobe", ackSeen, 1'b1);
    chk("ackByte", rdData_q, 8'hCF);
    chk("ackOff", intEnable_q, 1'b0);
    chk("ackPtr", nextFetchPointer_q, p0);
    multiModeIrq = 1'b0;
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    errors = 0;
    numChecks = 0;
    reset = 1'b1;
    {cmdValid, cmdLast, ptrLoad, intEnableSet, intEnableClr} = 5'h00;
    {maskLoad, modeLoad, vectorLoad, multiModeIrq} = 4'h0;
    busHoldRequest_n = 1'b1;
    waitRequest_n = 1'b1;
    cmdKind = cmbi_pkg::CK_FETCH;
    {cmdAddr, ptrLoadValue} = 32'h0000_0000;
    {cmdData, vectorValue, maskValue, modeValue} = 22'h00_0000;
    repeat (5) step();
    t_reset();
    repeat (5) step();
    reset = 1'b0;
    t_clock();
    repeat (4) step();
    t_memory();
    t_fetch();
    t_io();
    t_hold();
    t_irq();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    close_out();
  end
endmodule
